//--- sync_serial_pkg.sv
// Constants, types and field layouts shared by the synchronous serial frame engine
// How it works
// - All four interrupt sources OR into one line
// - Each source gated by its own mask bit
// - Raw and masked source states both readable
// - Frames carry 4 to 16 bits, MSB first
// - Shift clock idles, toggles only while transferring
// - Idle clock with waiting receive data flags timeout
// - SPI and control-word frame line low whole frame
// - Pulse-framed: one-period frame pulse before each frame
// - Pulse-framed: drive on rise, sample on fall
// - Control-word format sends 8 bits, ignores input meanwhile
// - Peripheral waits one clock then returns data
// - Pulse-framed idle: clock, frame low, output floating
// - Pulse-framed: valid entry pulses frame, loads shifter
// - Pulse-framed: MSB driven on rise after pulse
// - Pulse-framed: push received word on next rise
// - SPI polarity bit sets idle clock level
// - SPI phase bit picks first or second edge
// - SPI idle: clock at polarity level, frame high, master drives
// - SPI start: frame low, data, then clock
// - SPI mode 0: sample rising, change falling
// - Frame line high one period after last sample
// - Phase zero: frame pulses high between words
// - Transmit and receive FIFOs, eight by sixteen
// - Shift rate is clock over prescale times (1 + rate)
package sync_serial_pkg;

    // ==========================================================
    // Frame formats
    localparam logic [1:0] FMT_PULSE = 2'h0;
    localparam logic [1:0] FMT_SPI = 2'h1;
    localparam logic [1:0] FMT_CTRLWORD = 2'h2;

    // ==========================================================
    // Buffering
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int LEVEL_W = 4;
    localparam logic [3:0] TX_SERVICE_LEVEL = 4'h4;
    localparam logic [3:0] RX_SERVICE_LEVEL = 4'h4;

    // ==========================================================
    // Frame layout
    localparam logic [3:0] MIN_SIZE_CODE = 4'h3;
    localparam logic [4:0] CTRL_BITS = 5'h08;
    localparam logic [4:0] CTRL_GAP_BITS = 5'h09;

    // ==========================================================
    // Receive timeout, in idle shift-clock periods and half periods
    localparam int TIMEOUT_PERIODS = 32;
    localparam logic [6:0] TIMEOUT_HALVES = 7'(2 * TIMEOUT_PERIODS);

    // ==========================================================
    // Interrupt source positions and reset value
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_TIMEOUT = 2;
    localparam int IRQ_OVERRUN = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // ==========================================================
    // Engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_SHIFT = 2'b10,
        ST_TAIL = 2'b11
    } engine_state_t;

endpackage

//--- sync_serial_frame_engine.sv
// Serial frame engine with its transmit and receive FIFOs
`timescale 1ns/1ps

// ==========================================================
// Parameterised FIFO with registered flags and head word
module sync_serial_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int LW = 4
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Filling side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Draining side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready,
    // Fill level
    output logic [LW-1:0] o_level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;

    // Handshakes and next pointers
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;
    wire [AW-1:0] next_wr = push ? wr_ptr + AW'(1) : wr_ptr;
    wire [AW-1:0] next_rd = pop ? rd_ptr + AW'(1) : rd_ptr;
    wire [LW-1:0] next_level = o_level + LW'(push) - LW'(pop);
    // A word written into the slot about to become head bypasses the array
    wire [WIDTH-1:0] next_head = (push && next_rd == wr_ptr) ? i_in_data : mem[next_rd];

    // Storage has no reset; only pointers and flags matter after reset
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // Pointers, level and flags
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            o_level <= '0;
            o_in_ready <= 1'b1;
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end else begin
            wr_ptr <= next_wr;
            rd_ptr <= next_rd;
            o_level <= next_level;
            o_in_ready <= next_level != LW'(DEPTH);
            o_out_valid <= next_level != '0;
            o_out_data <= next_head;
        end
    end
endmodule

// ==========================================================
// Frame engine top
module sync_serial_frame_engine (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Configuration
    input wire logic i_enable,
    input wire logic i_master,
    input wire logic [1:0] i_format,
    input wire logic i_idle_clock_level,
    input wire logic i_capture_edge_select,
    input wire logic [3:0] i_data_size,
    input wire logic [7:0] i_prescale_divisor,
    input wire logic [7:0] i_serial_rate_field,
    // Transmit words from software
    input wire logic i_tx_valid,
    input wire logic [15:0] i_tx_data,
    output logic o_tx_ready,
    // Received words to software
    output logic o_rx_valid,
    output logic [15:0] o_rx_data,
    input wire logic i_rx_ready,
    // Interrupt sources
    input wire logic [3:0] i_irq_enable_reg,
    input wire logic i_overrun_clear,
    input wire logic i_timeout_clear,
    output logic [3:0] o_irq_raw_reg,
    output logic [3:0] o_irq_masked_reg,
    output logic o_irq,
    // Serial pins
    output logic o_shift_clock_pin,
    output logic o_shift_clock_oe_n,
    output logic o_frame_select_pin,
    output logic o_serial_out_pin,
    output logic o_serial_out_oe_n,
    input wire logic i_serial_in_pin
);
    sync_serial_pkg::engine_state_t state;
    logic hp;
    logic tail_left;
    logic [4:0] bit_idx;
    logic [15:0] tx_shift;
    logic [15:0] rx_shift;
    logic rx_push;
    logic [15:0] rx_word;
    logic [6:0] pre_cnt;
    logic [7:0] rate_cnt;
    logic [6:0] to_cnt;
    logic tx_valid;
    logic [15:0] tx_data;
    logic [3:0] tx_level;
    logic [3:0] rx_level;
    logic rx_in_ready;

    // ==========================================================
    // Format decode
    wire run = i_enable && i_master;
    wire is_pulse = i_format == sync_serial_pkg::FMT_PULSE;
    wire is_spi = i_format == sync_serial_pkg::FMT_SPI;
    wire is_ctrl = i_format == sync_serial_pkg::FMT_CTRLWORD;
    wire cpha1 = is_spi && i_capture_edge_select;
    wire idle_level = is_spi && i_idle_clock_level;
    wire [3:0] size_code = (i_data_size < sync_serial_pkg::MIN_SIZE_CODE) ?
        sync_serial_pkg::MIN_SIZE_CODE : i_data_size;
    // Control-word frames add 8 control bits and one turnaround clock
    wire [4:0] last_idx = is_ctrl ? 5'(size_code) + sync_serial_pkg::CTRL_GAP_BITS : 5'(size_code);

    // ==========================================================
    // Half-period tick: prescale/2 times (1 + rate) system clocks
    wire [6:0] half_div = (i_prescale_divisor[7:1] == 7'h00) ? 7'h01 : i_prescale_divisor[7:1];
    wire pre_end = pre_cnt == half_div - 7'h01;
    wire rate_end = rate_cnt == i_serial_rate_field;
    wire tick = run && pre_end && rate_end;

    always_ff @(posedge i_clock) begin
        if (!i_rstn || !run || (pre_end && rate_end)) begin
            pre_cnt <= 7'h00;
            rate_cnt <= 8'h00;
        end else if (pre_end) begin
            pre_cnt <= 7'h00;
            rate_cnt <= rate_cnt + 8'h01;
        end else begin
            pre_cnt <= pre_cnt + 7'h01;
        end
    end

    // ==========================================================
    // Bit selection: MSB first; control-word frames send only 8 bits
    function automatic logic tx_bit(input logic [4:0] idx);
        logic r;
        r = 1'b0;
        if (is_ctrl) begin
            if (idx < sync_serial_pkg::CTRL_BITS) begin
                r = tx_shift[3'(3'h7 - idx[2:0])];
            end
        end else if (idx <= 5'(size_code)) begin
            r = tx_shift[4'(size_code - idx[3:0])];
        end
        return r;
    endfunction

    // Sampling edge per format and phase
    wire in_shift = state == sync_serial_pkg::ST_SHIFT;
    wire sample_now = in_shift && (is_pulse || cpha1 ? hp : !hp);
    // Nothing is captured while the control word goes out
    wire capture_en = !is_ctrl || bit_idx >= sync_serial_pkg::CTRL_GAP_BITS;
    wire [15:0] rx_next = {rx_shift[14:0], i_serial_in_pin};
    wire last_bit = in_shift && hp && bit_idx == last_idx;
    wire in_tail = state == sync_serial_pkg::ST_TAIL;

    // Transmit FIFO pops: from idle, back-to-back phase one, pulse-framed run-on
    wire start_idle = state == sync_serial_pkg::ST_IDLE;
    wire tx_pop = tick && tx_valid &&
        (start_idle || (last_bit && cpha1) || (in_tail && is_pulse && !hp));
    wire push_now = tick && ((sample_now && bit_idx == last_idx && !is_pulse) ||
        (in_tail && is_pulse && !hp));

    // ==========================================================
    // Frame sequencer, stepped by half-period ticks
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state <= sync_serial_pkg::ST_IDLE;
            hp <= 1'b0;
            tail_left <= 1'b0;
            bit_idx <= 5'h00;
            tx_shift <= 16'h0000;
            rx_shift <= 16'h0000;
            o_shift_clock_pin <= 1'b0;
            o_shift_clock_oe_n <= 1'b1;
            o_frame_select_pin <= 1'b1;
            o_serial_out_pin <= 1'b0;
            o_serial_out_oe_n <= 1'b1;
        end else if (!run || start_idle) begin
            // Idle levels hold every cycle so a format change shows at once
            state <= sync_serial_pkg::ST_IDLE;
            o_shift_clock_pin <= idle_level;
            o_shift_clock_oe_n <= !i_master;
            o_frame_select_pin <= !is_pulse;
            o_serial_out_pin <= 1'b0;
            o_serial_out_oe_n <= is_pulse;
            if (tx_pop) begin
                tx_shift <= tx_data;
                rx_shift <= 16'h0000;
                bit_idx <= 5'h00;
                hp <= 1'b0;
                state <= sync_serial_pkg::ST_LEAD;
                o_frame_select_pin <= is_pulse;
                o_shift_clock_pin <= is_pulse;
                o_serial_out_oe_n <= is_pulse;
            end
        end else if (tick) begin
            case (state)
                sync_serial_pkg::ST_LEAD: begin
                    state <= sync_serial_pkg::ST_SHIFT;
                    if (is_pulse) begin
                        o_shift_clock_pin <= 1'b0;
                    end else if (!cpha1) begin
                        o_serial_out_pin <= tx_bit(5'h00);
                    end
                end
                sync_serial_pkg::ST_SHIFT: begin
                    hp <= !hp;
                    if (sample_now && capture_en) begin
                        rx_shift <= rx_next;
                    end
                    if (!hp) begin
                        o_shift_clock_pin <= is_pulse ? 1'b1 : !idle_level;
                        if (is_pulse) begin
                            o_frame_select_pin <= 1'b0;
                            o_serial_out_oe_n <= 1'b0;
                            o_serial_out_pin <= tx_bit(bit_idx);
                        end else if (cpha1) begin
                            o_serial_out_pin <= tx_bit(bit_idx);
                        end
                    end else begin
                        o_shift_clock_pin <= is_pulse ? 1'b0 : idle_level;
                        if (bit_idx != last_idx) begin
                            bit_idx <= bit_idx + 5'h01;
                            if (!is_pulse && !cpha1) begin
                                o_serial_out_pin <= tx_bit(bit_idx + 5'h01);
                            end
                        end else if (tx_pop) begin
                            // Phase one keeps the frame low across words
                            tx_shift <= tx_data;
                            rx_shift <= 16'h0000;
                            bit_idx <= 5'h00;
                        end else begin
                            state <= sync_serial_pkg::ST_TAIL;
                            tail_left <= cpha1;
                        end
                    end
                end
                sync_serial_pkg::ST_TAIL: begin
                    if (is_pulse) begin
                        hp <= !hp;
                        o_shift_clock_pin <= !hp;
                        if (tx_pop) begin
                            tx_shift <= tx_data;
                            rx_shift <= 16'h0000;
                            bit_idx <= 5'h00;
                            hp <= 1'b0;
                            o_frame_select_pin <= 1'b1;
                            state <= sync_serial_pkg::ST_LEAD;
                        end else if (hp) begin
                            o_serial_out_oe_n <= 1'b1;
                            state <= sync_serial_pkg::ST_IDLE;
                        end
                    end else if (tail_left) begin
                        tail_left <= 1'b0;
                    end else begin
                        // Idle stretch before the next load makes the high pulse
                        o_frame_select_pin <= 1'b1;
                        o_serial_out_pin <= 1'b0;
                        state <= sync_serial_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= sync_serial_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Received word hand-off to the receive FIFO
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            rx_push <= 1'b0;
            rx_word <= 16'h0000;
        end else begin
            rx_push <= push_now;
            rx_word <= is_pulse ? rx_shift : rx_next;
        end
    end

    // ==========================================================
    // Eight-deep FIFOs on both paths
    sync_serial_fifo #(.WIDTH(sync_serial_pkg::FIFO_WIDTH), .DEPTH(sync_serial_pkg::FIFO_DEPTH),
        .LW(sync_serial_pkg::LEVEL_W)) u_tx_fifo (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_in_valid(i_tx_valid),
        .i_in_data(i_tx_data),
        .o_in_ready(o_tx_ready),
        .o_out_valid(tx_valid),
        .o_out_data(tx_data),
        .i_out_ready(tx_pop),
        .o_level(tx_level)
    );

    sync_serial_fifo #(.WIDTH(sync_serial_pkg::FIFO_WIDTH), .DEPTH(sync_serial_pkg::FIFO_DEPTH),
        .LW(sync_serial_pkg::LEVEL_W)) u_rx_fifo (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_in_valid(rx_push),
        .i_in_data(rx_word),
        .o_in_ready(rx_in_ready),
        .o_out_valid(o_rx_valid),
        .o_out_data(o_rx_data),
        .i_out_ready(i_rx_ready),
        .o_level(rx_level)
    );

    // ==========================================================
    // Receive timeout: counts idle half periods while data waits
    wire rx_pop = o_rx_valid && i_rx_ready;
    wire to_restart = rx_push || rx_pop || !start_idle || rx_level == 4'h0;
    wire to_hit = tick && !to_restart && to_cnt == sync_serial_pkg::TIMEOUT_HALVES - 7'h01;

    always_ff @(posedge i_clock) begin
        if (!i_rstn || to_restart) begin
            to_cnt <= 7'h00;
        end else if (tick && to_cnt != sync_serial_pkg::TIMEOUT_HALVES) begin
            to_cnt <= to_cnt + 7'h01;
        end
    end

    // ==========================================================
    // Interrupt sources: sticky bits let a set win over a clear
    wire overrun_set = rx_push && !rx_in_ready;
    wire next_overrun = overrun_set || (o_irq_raw_reg[sync_serial_pkg::IRQ_OVERRUN] && !i_overrun_clear);
    wire next_timeout = to_hit ||
        (o_irq_raw_reg[sync_serial_pkg::IRQ_TIMEOUT] && !i_timeout_clear && !rx_pop);
    wire [3:0] next_raw = {next_overrun, next_timeout,
        rx_level >= sync_serial_pkg::RX_SERVICE_LEVEL, tx_level <= sync_serial_pkg::TX_SERVICE_LEVEL};
    wire [3:0] next_masked = next_raw & i_irq_enable_reg;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_irq_raw_reg <= sync_serial_pkg::IRQ_RESET;
            o_irq_masked_reg <= sync_serial_pkg::IRQ_RESET;
            o_irq <= 1'b0;
        end else begin
            o_irq_raw_reg <= next_raw;
            o_irq_masked_reg <= next_masked;
            o_irq <= |next_masked;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    irq_or_a: assert property (o_irq == |o_irq_masked_reg) else $error("irq differs from masked OR");
    mask_gate_a: assert property (##1 o_irq_masked_reg == (o_irq_raw_reg & $past(i_irq_enable_reg)))
        else $error("masked status not raw and enable");
    idle_level_a: assert property ((start_idle && run && is_spi && !tx_pop) |=>
        o_shift_clock_pin == $past(i_idle_clock_level)) else $error("spi idle clock level wrong");
    frame_low_a: assert property ((in_shift && !is_pulse) |-> !o_frame_select_pin)
        else $error("frame line high mid frame");
    pulse_idle_a: assert property ((start_idle && is_pulse && !tx_pop && $past(start_idle) &&
        $stable(i_format)) |=> (!o_shift_clock_pin && !o_frame_select_pin && o_serial_out_oe_n))
        else $error("pulse idle pins");
    bit_range_a: assert property (in_shift |-> bit_idx <= last_idx) else $error("bit index past frame");
    overrun_set_a: assert property (overrun_set |=> o_irq_raw_reg[sync_serial_pkg::IRQ_OVERRUN])
        else $error("overrun not flagged");
    ctrl_quiet_a: assert property ((tick && in_shift && is_ctrl && bit_idx < sync_serial_pkg::CTRL_GAP_BITS)
        |=> rx_shift == $past(rx_shift)) else $error("input taken during control word");
    clock_pad_a: assert property (!i_master |=> o_shift_clock_oe_n) else $error("slave drives clock pad");
    timeout_src_a: assert property ($rose(o_irq_raw_reg[sync_serial_pkg::IRQ_TIMEOUT]) |->
        $past(rx_level != 4'h0 && start_idle)) else $error("timeout without waiting data");

    spi_word_c: cover property (is_spi && rx_push);
    pulse_word_c: cover property (is_pulse && rx_push);
    ctrl_word_c: cover property (is_ctrl && rx_push);
    overrun_c: cover property (overrun_set);
endmodule

//--- serial_peer_model.sv
// Behavioural off-chip peripheral answering SPI mode 0, control-word and pulse-framed frames
`timescale 1ns/1ps
module serial_peer_model (
    // Clock
    input wire logic i_clock,
    // Setup
    input wire logic i_pulse_mode,
    input wire logic [4:0] i_bits,
    input wire logic [15:0] i_reply,
    // Link pins
    input wire logic i_sclk,
    input wire logic i_frame,
    input wire logic i_mosi,
    output logic o_miso,
    output logic [15:0] o_rx_word
);
    logic sclk_q = 1'b0;
    logic frame_q = 1'b1;
    logic idle_bit = 1'b0;
    logic [15:0] shifter = 16'h0000;
    logic [4:0] count = 5'h00;
    // Pins move only on engine clock edges, so edges are found against last cycle
    wire clk_rise = i_sclk && !sclk_q;
    wire clk_fall = !i_sclk && sclk_q;
    wire start = i_pulse_mode ? (i_frame && !frame_q) : (!i_frame && frame_q);
    wire in_frame = i_pulse_mode ? (i_frame || count < i_bits) : !i_frame;
    wire sample_edge = i_pulse_mode ? (clk_fall && !i_frame) : clk_rise;
    wire shift_edge = i_pulse_mode ? (clk_rise && !frame_q) : clk_fall;
    // A released line toggles so a stale bit never passes for a good one
    assign o_miso = in_frame ? shifter[15] : idle_bit;
    initial o_rx_word = 16'h0000;
    // Shift out the reply and count in the captured bits
    always @(posedge i_clock) begin
        sclk_q <= i_sclk;
        frame_q <= i_frame;
        idle_bit <= ~idle_bit;
        if (start) begin
            shifter <= i_reply << (5'h10 - i_bits);
            count <= 5'h00;
        end else if (in_frame && shift_edge) begin
            shifter <= shifter << 1;
        end
        if (!start && in_frame && sample_edge && count < i_bits) begin
            o_rx_word <= {o_rx_word[14:0], i_mosi};
            count <= count + 5'h01;
        end
    end
endmodule

//--- test_sync_serial_frame_engine.sv
// Self-checking bench for the serial frame engine
`timescale 1ns/1ps
module test_sync_serial_frame_engine;
    logic i_clock = 1'b0, i_rstn = 1'b0, i_enable = 1'b0, i_master = 1'b1;
    logic [1:0] i_format = sync_serial_pkg::FMT_SPI;
    logic i_idle_clock_level = 1'b0, i_capture_edge_select = 1'b0;
    logic [3:0] i_data_size = 4'h7, i_irq_enable_reg = 4'h0;
    logic [7:0] i_prescale_divisor = 8'h04, i_serial_rate_field = 8'h00;
    logic i_tx_valid = 1'b0, i_rx_ready = 1'b0, i_overrun_clear = 1'b0, i_timeout_clear = 1'b0;
    logic [15:0] i_tx_data = 16'h0000, reply = 16'hF0A5, o_rx_data, peer_word;
    logic o_tx_ready, o_rx_valid, o_irq, o_shift_clock_pin, o_shift_clock_oe_n;
    logic o_frame_select_pin, o_serial_out_pin, o_serial_out_oe_n, i_serial_in_pin;
    logic [3:0] o_irq_raw_reg, o_irq_masked_reg;
    int bad_count = 0, comparisons = 0, cycles = 0;
    sync_serial_frame_engine i_sync_serial_frame_engine (.*);
    serial_peer_model i_serial_peer_model (.i_clock(i_clock),
        .i_pulse_mode(i_format == sync_serial_pkg::FMT_PULSE),
        // Control-word frames: the peer samples every bit and shifts its whole reply from the first clock
        .i_bits(i_format == sync_serial_pkg::FMT_CTRLWORD ? 5'h10 : 5'(i_data_size) + 5'h01),
        .i_reply(reply), .i_sclk(o_shift_clock_pin), .i_frame(o_frame_select_pin),
        .i_mosi(o_serial_out_pin), .o_miso(i_serial_in_pin), .o_rx_word(peer_word));
    // ==========================================================
    // Clock and watchdog; the whole run needs about a thousand cycles
    always #25 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic push_word(input logic [15:0] w);
        @(negedge i_clock);
        i_tx_valid = 1'b1;
        i_tx_data = w;
        @(negedge i_clock);
        i_tx_valid = 1'b0;
    endtask
    task automatic pop_word(input logic [15:0] want);
        @(negedge i_clock);
        check(16'(o_rx_valid), 16'h0001);
        check(o_rx_data, want);
        i_rx_ready = 1'b1;
        @(negedge i_clock);
        i_rx_ready = 1'b0;
    endtask
    // Idle means frame at its rest level and the clock still for 24 cycles
    task automatic wait_idle(input logic level);
        int run;
        run = 0;
        for (int k = 0; k < 3000 && run < 24; k++) begin
            @(negedge i_clock);
            run = (o_frame_select_pin === level && o_shift_clock_pin === i_idle_clock_level) ? run + 1 : 0;
        end
        check(16'(run), 16'h0018);
    endtask
    task automatic wait_raw(input int b);
        for (int k = 0; k < 400 && o_irq_raw_reg[b] !== 1'b1; k++) @(negedge i_clock);
        check(16'(o_irq_raw_reg[b]), 16'h0001);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================================
    // Test sequence
    initial begin
        repeat (8) @(negedge i_clock);
        check(16'({o_tx_ready, o_rx_valid, o_irq, o_frame_select_pin, o_irq_raw_reg}), 16'h0090);
        i_rstn = 1'b1;
        // Fill the transmit store while disabled, then one refused write
        for (int i = 0; i < 8; i++) push_word(16'h0030 + 16'(i));
        push_word(16'h00FF);
        check(16'(o_tx_ready), 16'h0000);
        i_enable = 1'b1;
        wait_idle(1'b1);
        check(16'(peer_word[7:0]), 16'h0037);
        check(16'(o_irq_raw_reg[1:0]), 16'h0003);
        check(16'(o_irq), 16'h0000);
        i_irq_enable_reg = 4'h2;
        repeat (3) @(negedge i_clock);
        check(16'({o_irq_masked_reg, 3'h0, o_irq}), 16'h0021);
        // Ninth word lands on a full receive store
        push_word(16'h0038);
        wait_raw(sync_serial_pkg::IRQ_OVERRUN);
        wait_raw(sync_serial_pkg::IRQ_TIMEOUT);
        i_overrun_clear = 1'b1;
        @(negedge i_clock);
        i_overrun_clear = 1'b0;
        @(negedge i_clock);
        check(16'(o_irq_raw_reg[3]), 16'h0000);
        for (int i = 0; i < 8; i++) pop_word(16'h00A5);
        check(16'(o_rx_valid), 16'h0000);
        @(negedge i_clock);
        check(16'(o_irq_raw_reg[2]), 16'h0000);
        i_idle_clock_level = 1'b1;
        repeat (4) @(negedge i_clock);
        check(16'(o_shift_clock_pin), 16'h0001);
        i_idle_clock_level = 1'b0;
        // A slave releases the clock pad; a master takes it back
        i_master = 1'b0;
        repeat (3) @(negedge i_clock);
        check(16'(o_shift_clock_oe_n), 16'h0001);
        i_master = 1'b1;
        repeat (3) @(negedge i_clock);
        check(16'(o_shift_clock_oe_n), 16'h0000);
        // Pulse-framed word of the full sixteen bits
        i_format = sync_serial_pkg::FMT_PULSE;
        i_data_size = 4'hF;
        reply = 16'h5A3C;
        repeat (4) @(negedge i_clock);
        check(16'({o_frame_select_pin, o_serial_out_oe_n, o_shift_clock_pin}), 16'h0002);
        push_word(16'hC3A5);
        wait_idle(1'b0);
        check(peer_word, 16'hC3A5);
        pop_word(16'h5A3C);
        // Control-word frame at a slower rate; reply bits seen during the control byte must be dropped
        i_format = sync_serial_pkg::FMT_CTRLWORD;
        i_data_size = 4'h3;
        i_serial_rate_field = 8'h01;
        reply = 16'hFF50;
        repeat (4) @(negedge i_clock);
        push_word(16'h00C6);
        wait_idle(1'b1);
        check(16'(peer_word[12:5]), 16'h00C6);
        wait_raw(sync_serial_pkg::IRQ_TIMEOUT);
        i_timeout_clear = 1'b1;
        @(negedge i_clock);
        i_timeout_clear = 1'b0;
        @(negedge i_clock);
        check(16'(o_irq_raw_reg[2]), 16'h0000);
        pop_word(16'h000A);
        report_and_stop();
    end
endmodule
